/* File: wsf_pkg.sv */
// Package for the wheel sensor adaptive filter: register map, fields,
// timing constants and carrier structs.
// Assumes a 100 MHz clock and a 32-bit classic Wishbone register bus.
package wsf_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int T_FILT_MIN_US = 4;
   localparam int T_FILT_MAX_US = 200;
   localparam int T_DIAG_MS = 5;
   localparam int FILT_MIN_CYC = T_FILT_MIN_US * CLK_MHZ;
   localparam int FILT_MAX_CYC = T_FILT_MAX_US * CLK_MHZ;
   localparam int DIAG_CYC = T_DIAG_MS * 1000 * CLK_MHZ;
   localparam int PER_W = 24;
   localparam int PER_SHIFT = 5;

   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_MODE = 8'h00;
   localparam logic [7:0] ADDR_HYST = 8'h04;
   localparam logic [7:0] ADDR_OVRD = 8'h08;
   localparam logic [7:0] ADDR_DIAG = 8'h0C;
   localparam logic [7:0] ADDR_STAT = 8'h10;
   localparam logic [7:0] ADDR_IRQ_ST = 8'h14;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h18;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h1C;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int MODE_EN_BIT = 0;
   localparam int MODE_FULL_BIT = 1;
   localparam int MODE_CODE_LSB = 2;
   localparam int HYST_MIN_LSB = 0;
   localparam int HYST_FORCE_BIT = 5;
   localparam int OVRD_FIXED_BIT = 4;
   localparam int DIAG_REQ_BIT = 0;
   localparam int HYST_W = 3;
   localparam int IRQ_W = 2;
   localparam int IRQ_DIAG_DONE = 0;
   localparam int IRQ_EDGE = 1;

   // ----------------------------------------------------------------
   // Reset values and codes
   // ----------------------------------------------------------------
   localparam logic [1:0] CODE_RISE_COMP = 2'h0;
   localparam logic [1:0] CODE_RISE_FILT = 2'h1;
   localparam logic [1:0] CODE_BOTH_COMP = 2'h2;
   localparam logic [1:0] CODE_BOTH_FILT = 2'h3;
   localparam logic [HYST_W-1:0] HYST_LOWEST = 3'h0;
   localparam logic [HYST_W-1:0] HYST_MIN_RST = 3'h0;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic enable;
      logic full_adaptive;
      logic [1:0] code;
      logic fixed_filter;
      logic hyst_force;
      logic [HYST_W-1:0] hyst_min;
   } wsf_cfg_t;

   typedef struct packed {
      logic sensor_open;
      logic short_gnd;
      logic short_bat;
   } wsf_fault_t;

   typedef enum logic [1:0] {
      DG_IDLE = 2'b00,
      DG_RUN = 2'b01,
      DG_DONE = 2'b11
   } wsf_diag_st_t;

endpackage

/* File: wsf_edge_filter.sv */
// Edge filter and masking of the squared wheel signal.
// Assumes the squared comparator signal is synchronous to clk_i.
`timescale 1ns/10ps
module wsf_edge_filter #(
   parameter int PER_W = wsf_pkg::PER_W
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic active_i,
   input wire logic both_edges_i,
   input wire logic sq_i,
   input wire logic [PER_W-1:0] tfilt_i,
   output logic out_o,
   output logic rise_o
);

   logic sq_d_ff;
   logic [PER_W-1:0] cnt_ff;
   logic mask_ff;

   // ----------------------------------------------------------------
   // Delay rising edges, mask or delay falling edges
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || !active_i) begin
         out_o <= 1'b0;
         cnt_ff <= '0;
         mask_ff <= 1'b0;
         sq_d_ff <= 1'b0;
         rise_o <= 1'b0;
      end else begin
         sq_d_ff <= sq_i;
         rise_o <= 1'b0;
         if (mask_ff) begin
            // Transitions ignored during masking [RULE3]
            if (cnt_ff >= tfilt_i) begin
               mask_ff <= 1'b0;
               cnt_ff <= '0;
            end else begin
               cnt_ff <= cnt_ff + 1'b1;
            end
         end else if (sq_i != out_o) begin
            if (!out_o || both_edges_i) begin
               // Edge passes only after stable for filter time [RULE3] [RULE5]
               if (sq_i != sq_d_ff) begin
                  cnt_ff <= '0;
               end else if (cnt_ff >= tfilt_i) begin
                  out_o <= sq_i;
                  rise_o <= sq_i;
                  cnt_ff <= '0;
               end else begin
                  cnt_ff <= cnt_ff + 1'b1;
               end
            end else begin
               // Falling edge passes at once, then mask [RULE3]
               out_o <= 1'b0;
               mask_ff <= 1'b1;
               cnt_ff <= '0;
            end
         end else begin
            cnt_ff <= '0;
         end
      end
   end

   property p_fall_mask;
      @(posedge clk_i) disable iff (rst_i)
      (active_i && !both_edges_i && out_o && !sq_i && !mask_ff)
      |=> (!out_o && mask_ff);
   endproperty
   a_fall_mask: assert property (p_fall_mask) // [RULE3]
      else $error("falling edge not followed by masking");

   property p_rise_out;
      @(posedge clk_i) disable iff (rst_i)
      rise_o |-> out_o;
   endproperty
   a_rise_out: assert property (p_rise_out) // [RULE3]
      else $error("rise flag without filtered output high");

endmodule

/* File: wsf_diag.sv */
// Sensor diagnosis sequencer: runs at least the settle time, then
// latches result and state.
// Assumes fault inputs from the analogue front end are synchronous.
`timescale 1ns/10ps
module wsf_diag #(
   parameter int DIAG_CYC = wsf_pkg::DIAG_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic req_i,
   input wire wsf_pkg::wsf_fault_t fault_i,
   output logic busy_o,
   output logic done_o,
   output logic result_o,
   output logic state_o
);

   localparam int CW = $clog2(DIAG_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(DIAG_CYC - 1);

   wsf_pkg::wsf_diag_st_t st_ff;
   logic [CW-1:0] cnt_ff;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= wsf_pkg::DG_IDLE;
         cnt_ff <= '0;
         done_o <= 1'b0;
         result_o <= 1'b0;
         state_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         case (st_ff)
            wsf_pkg::DG_IDLE: begin
               cnt_ff <= '0;
               if (req_i) begin
                  st_ff <= wsf_pkg::DG_RUN; // [RULE12]
               end
            end
            wsf_pkg::DG_RUN: begin
               if (cnt_ff == LAST) begin // [RULE14]
                  st_ff <= wsf_pkg::DG_DONE;
               end else begin
                  cnt_ff <= cnt_ff + 1'b1;
               end
            end
            wsf_pkg::DG_DONE: begin
               // Last step overwrites both bits [RULE15]
               result_o <= fault_i.sensor_open | fault_i.short_gnd
                  | fault_i.short_bat;
               state_o <= 1'b1;
               done_o <= 1'b1;
               st_ff <= wsf_pkg::DG_IDLE;
            end
            default: st_ff <= wsf_pkg::DG_IDLE;
         endcase
      end
   end

   assign busy_o = (st_ff != wsf_pkg::DG_IDLE);

   property p_min_time;
      @(posedge clk_i) disable iff (rst_i)
      (st_ff == wsf_pkg::DG_RUN) && (cnt_ff != LAST)
      |=> (st_ff == wsf_pkg::DG_RUN);
   endproperty
   a_min_time: assert property (p_min_time) // [RULE14]
      else $error("diagnosis ended early");

   property p_done_bits;
      @(posedge clk_i) disable iff (rst_i)
      done_o |-> (state_o && !busy_o);
   endproperty
   a_done_bits: assert property (p_done_bits) // [RULE15]
      else $error("completion without state bit or still busy");

endmodule

/* File: wsf_top.sv */
// Wheel sensor adaptive filter: Wishbone registers, adaptive filter
// time, hysteresis control and diagnosis.
// Assumes a synchronous squared comparator input and one 100 MHz clock.
//
// Overview of operation
// RULE1 - Two-bit code picks hysteresis feedback: comparator or filter output.
// RULE2 - Code picks filtering on rising edge only or on both edges.
// RULE3 - Codes 00/01: rise delayed period/32; fall then period/32 masking.
// RULE4 - Code 01 takes hysteresis feedback after the filter block.
// RULE5 - Code 10 filters falling edges too; code 11 combines 01 and 10.
// RULE6 - Fixed-filter bit holds filter time at about 4 us.
// RULE7 - Limited adaptive mode uses a fixed 4 us filter.
// RULE8 - Limited mode: hysteresis never below the programmed minimum.
// RULE9 - Hysteresis-override bit forces the lowest hysteresis level.
// RULE10 - Host clears the override bit after a new minimum.
// RULE11 - Diagnosis not offered in limited adaptive mode.
// RULE12 - Diagnosis request runs open/short checks on the sensor.
// RULE13 - During diagnosis the output does not follow the sensor.
// RULE14 - Diagnosis lasts at least 5 ms.
// RULE15 - Diagnosis ends by writing result and state bits.
// RULE16 - Fully adaptive: next filter time is previous period over 32.
// RULE17 - Filter time resets to 200 us max, min 4 us; enable resets.
// RULE18 - Mode bit picks full or limited adaptive; limited by default.
// RULE19 - Period, filter and mask timers are clocked counters reset.
//
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/10ps
module wsf_top #(
   parameter int PER_W = wsf_pkg::PER_W,
   parameter int DIAG_CYC = wsf_pkg::DIAG_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic [wsf_pkg::HYST_W-1:0] peak_level_i,
   input wire logic sq_i,
   input wire wsf_pkg::wsf_fault_t fault_i,
   output logic wheel_o,
   output logic hyst_fb_o,
   output logic [wsf_pkg::HYST_W-1:0] hyst_level_o,
   output logic diag_mode_o,
   output logic irq_o
);

   localparam logic [PER_W-1:0] TMAX = PER_W'(wsf_pkg::FILT_MAX_CYC);
   localparam logic [PER_W-1:0] TMIN = PER_W'(wsf_pkg::FILT_MIN_CYC);

   wsf_pkg::wsf_cfg_t cfg_ff;
   logic diag_req_ff;
   logic [wsf_pkg::IRQ_W-1:0] irq_st_ff;
   logic [wsf_pkg::IRQ_W-1:0] irq_en_ff;
   logic [PER_W-1:0] per_cnt_ff;
   logic [PER_W-1:0] tfilt_ff;
   logic [PER_W-1:0] tfilt_use;
   logic [PER_W-1:0] nxt_tfilt;
   logic en_d_ff;
   logic filt_out;
   logic filt_rise;
   logic diag_busy;
   logic diag_done;
   logic diag_res;
   logic diag_state;
   logic wb_req;
   logic wb_wr;
   logic [wsf_pkg::IRQ_W-1:0] irq_set;
   logic [31:0] rd_data;

   assign wb_req = cyc_i && stb_i && !ack_o;
   assign wb_wr = wb_req && we_i && sel_i[0];

   // ----------------------------------------------------------------
   // Wishbone slave: one wait state, ack for one cycle
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= wb_req;
         dat_o <= wb_req ? rd_data : 32'h0000_0000;
      end
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      case (adr_i)
         wsf_pkg::ADDR_MODE: begin
            rd_data[wsf_pkg::MODE_EN_BIT] = cfg_ff.enable;
            rd_data[wsf_pkg::MODE_FULL_BIT] = cfg_ff.full_adaptive;
            rd_data[wsf_pkg::MODE_CODE_LSB +: 2] = cfg_ff.code;
         end
         wsf_pkg::ADDR_HYST: begin
            rd_data[wsf_pkg::HYST_MIN_LSB +: wsf_pkg::HYST_W] =
               cfg_ff.hyst_min;
            rd_data[wsf_pkg::HYST_FORCE_BIT] = cfg_ff.hyst_force;
         end
         wsf_pkg::ADDR_OVRD: begin
            rd_data[wsf_pkg::OVRD_FIXED_BIT] = cfg_ff.fixed_filter;
         end
         wsf_pkg::ADDR_DIAG: begin
            rd_data[wsf_pkg::DIAG_REQ_BIT] = diag_busy;
         end
         wsf_pkg::ADDR_STAT: begin
            rd_data[0] = diag_res;
            rd_data[1] = diag_state;
            rd_data[2] = wheel_o;
            rd_data[PER_W+7:8] = tfilt_use;
         end
         wsf_pkg::ADDR_IRQ_ST: begin
            rd_data[wsf_pkg::IRQ_W-1:0] = irq_st_ff;
         end
         wsf_pkg::ADDR_IRQ_EN: begin
            rd_data[wsf_pkg::IRQ_W-1:0] = irq_en_ff;
         end
         default: rd_data = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_ff.enable <= 1'b0;
         cfg_ff.full_adaptive <= 1'b0; // [RULE18]
         cfg_ff.code <= wsf_pkg::CODE_RISE_COMP;
         cfg_ff.fixed_filter <= 1'b0;
         cfg_ff.hyst_force <= 1'b0;
         cfg_ff.hyst_min <= wsf_pkg::HYST_MIN_RST;
         irq_en_ff <= '0;
      end else if (wb_wr) begin
         case (adr_i)
            wsf_pkg::ADDR_MODE: begin
               cfg_ff.enable <= dat_i[wsf_pkg::MODE_EN_BIT];
               cfg_ff.full_adaptive <= dat_i[wsf_pkg::MODE_FULL_BIT];
               cfg_ff.code <= dat_i[wsf_pkg::MODE_CODE_LSB +: 2];
            end
            wsf_pkg::ADDR_HYST: begin
               cfg_ff.hyst_min <=
                  dat_i[wsf_pkg::HYST_MIN_LSB +: wsf_pkg::HYST_W];
               cfg_ff.hyst_force <= dat_i[wsf_pkg::HYST_FORCE_BIT];
            end
            wsf_pkg::ADDR_OVRD: begin
               cfg_ff.fixed_filter <= dat_i[wsf_pkg::OVRD_FIXED_BIT];
            end
            wsf_pkg::ADDR_IRQ_EN: begin
               irq_en_ff <= dat_i[wsf_pkg::IRQ_W-1:0];
            end
            default: ;
         endcase
      end
   end

   // Request pulse; ignored in limited mode or while busy [RULE11]
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         diag_req_ff <= 1'b0;
      end else begin
         diag_req_ff <= wb_wr && (adr_i == wsf_pkg::ADDR_DIAG)
            && dat_i[wsf_pkg::DIAG_REQ_BIT] && cfg_ff.full_adaptive
            && !diag_busy;
      end
   end

   // ----------------------------------------------------------------
   // Period measurement and adaptive filter time
   // ----------------------------------------------------------------
   always_comb begin
      nxt_tfilt = per_cnt_ff >> wsf_pkg::PER_SHIFT; // [RULE16]
      if (nxt_tfilt > TMAX) begin
         nxt_tfilt = TMAX; // [RULE17]
      end else if (nxt_tfilt < TMIN) begin
         nxt_tfilt = TMIN;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         per_cnt_ff <= '0; // [RULE19]
         tfilt_ff <= TMAX; // [RULE17]
         en_d_ff <= 1'b0;
      end else begin
         en_d_ff <= cfg_ff.enable;
         if (cfg_ff.enable && !en_d_ff) begin
            tfilt_ff <= TMAX; // [RULE17]
            per_cnt_ff <= '0;
         end else if (filt_rise) begin
            // Every filtered rise loads the clamped period/32 [RULE16]
            tfilt_ff <= nxt_tfilt;
            per_cnt_ff <= '0;
         end else if (per_cnt_ff != '1) begin
            per_cnt_ff <= per_cnt_ff + 1'b1;
         end
      end
   end

   // Fixed 4 us in limited mode or with the fixed bit [RULE6] [RULE7]
   assign tfilt_use = (cfg_ff.fixed_filter || !cfg_ff.full_adaptive)
      ? TMIN : tfilt_ff;

   wsf_edge_filter #(
      .PER_W(PER_W)
   ) u_filt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .active_i(cfg_ff.enable && !diag_busy),
      .both_edges_i(cfg_ff.code[1]), // [RULE2] [RULE5]
      .sq_i(sq_i),
      .tfilt_i(tfilt_use),
      .out_o(filt_out),
      .rise_o(filt_rise)
   );

   wsf_diag #(
      .DIAG_CYC(DIAG_CYC)
   ) u_diag (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .req_i(diag_req_ff),
      .fault_i(fault_i),
      .busy_o(diag_busy),
      .done_o(diag_done),
      .result_o(diag_res),
      .state_o(diag_state)
   );

   // ----------------------------------------------------------------
   // Outputs: wheel, hysteresis feedback and level
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wheel_o <= 1'b0;
         hyst_fb_o <= 1'b0;
         hyst_level_o <= wsf_pkg::HYST_LOWEST;
         diag_mode_o <= 1'b0;
      end else begin
         wheel_o <= diag_busy ? 1'b0 : filt_out; // [RULE13]
         diag_mode_o <= diag_busy;
         // Feedback source by code bit 0 [RULE1] [RULE4]
         hyst_fb_o <= cfg_ff.code[0] ? filt_out : sq_i;
         if (cfg_ff.hyst_force) begin
            hyst_level_o <= wsf_pkg::HYST_LOWEST; // [RULE9]
         end else if (!cfg_ff.full_adaptive
               && peak_level_i < cfg_ff.hyst_min) begin
            hyst_level_o <= cfg_ff.hyst_min; // [RULE8]
         end else begin
            hyst_level_o <= peak_level_i;
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupts: set wins over clear
   // ----------------------------------------------------------------
   assign irq_set = {filt_rise, diag_done};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_st_ff <= '0;
         irq_o <= 1'b0;
      end else begin
         if (wb_wr && adr_i == wsf_pkg::ADDR_IRQ_CLR) begin
            irq_st_ff <= (irq_st_ff & ~dat_i[wsf_pkg::IRQ_W-1:0])
               | irq_set;
         end else begin
            irq_st_ff <= irq_st_ff | irq_set;
         end
         irq_o <= |(irq_st_ff & irq_en_ff);
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_force_low;
      @(posedge clk_i) disable iff (rst_i)
      cfg_ff.hyst_force |=> (hyst_level_o == wsf_pkg::HYST_LOWEST);
   endproperty
   a_force_low: assert property (p_force_low) // [RULE9]
      else $error("override did not force lowest hysteresis");

   property p_hyst_min;
      @(posedge clk_i) disable iff (rst_i)
      (!cfg_ff.full_adaptive && !cfg_ff.hyst_force)
      |=> (hyst_level_o >= $past(cfg_ff.hyst_min));
   endproperty
   a_hyst_min: assert property (p_hyst_min) // [RULE8]
      else $error("hysteresis below minimum in limited mode");

   property p_fixed;
      @(posedge clk_i) disable iff (rst_i)
      (cfg_ff.fixed_filter || !cfg_ff.full_adaptive) |-> tfilt_use == TMIN;
   endproperty
   a_fixed: assert property (p_fixed) // [RULE6]
      else $error("filter time not fixed");

   property p_no_diag_lim;
      @(posedge clk_i) disable iff (rst_i)
      !cfg_ff.full_adaptive |=> !diag_req_ff;
   endproperty
   a_no_diag_lim: assert property (p_no_diag_lim) // [RULE11]
      else $error("diagnosis started in limited mode");

   property p_diag_quiet;
      @(posedge clk_i) disable iff (rst_i)
      diag_busy |=> !wheel_o;
   endproperty
   a_diag_quiet: assert property (p_diag_quiet) // [RULE13]
      else $error("output followed sensor during diagnosis");

   property p_fb_src;
      @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> hyst_fb_o == ($past(cfg_ff.code[0]) ? $past(filt_out)
         : $past(sq_i));
   endproperty
   a_fb_src: assert property (p_fb_src) // [RULE1]
      else $error("wrong hysteresis feedback source");

   property p_reset_max;
      @(posedge clk_i) rst_i |=> tfilt_ff == TMAX;
   endproperty
   a_reset_max: assert property (p_reset_max) // [RULE17]
      else $error("filter time not at maximum after reset");

   property p_bounds;
      @(posedge clk_i) disable iff (rst_i)
      tfilt_ff >= TMIN && tfilt_ff <= TMAX;
   endproperty
   a_bounds: assert property (p_bounds) // [RULE16]
      else $error("filter time out of range");

   c_diag: cover property (@(posedge clk_i) disable iff (rst_i) diag_done);
   c_rise: cover property (@(posedge clk_i) disable iff (rst_i) filt_rise);
   c_irq: cover property (@(posedge clk_i) disable iff (rst_i) irq_o);

endmodule

/* File: wsf_sensor_model.sv */
// Behavioural wheel sensor and front end: squared pulses and fault levels.
// Assumes the bench pulses go_i for one cycle to launch a high pulse.
`timescale 1ns/10ps
module wsf_sensor_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic go_i,
   input wire logic [15:0] len_i,
   input wire logic [1:0] fsel_i,
   output logic sq_o,
   output wsf_pkg::wsf_fault_t fault_o
);
   // ----------------------------------------------------------------
   // Pulse generator: high for len_i cycles, then low
   // ----------------------------------------------------------------
   logic [15:0] cnt_ff;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_ff <= 16'h0000;
         sq_o <= 1'b0;
      end else if (go_i) begin
         cnt_ff <= len_i;
         sq_o <= 1'b1;
      end else if (cnt_ff != 16'h0000) begin
         cnt_ff <= cnt_ff - 16'h0001;
         sq_o <= (cnt_ff != 16'h0001);
      end
   end
   // One fault at a time, as an open or shorted sensor would show
   assign fault_o = {fsel_i == 2'h1, fsel_i == 2'h2, fsel_i == 2'h3};
endmodule

/* File: tb_wsf.sv */
// Self-checking bench for the wheel filter with a behavioural sensor.
// Assumes the register map of the package and a short diagnosis time.
`timescale 1ns/10ps
module testbench;
   localparam int DC = 50;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0, rd, q;
   logic [2:0] peak = 3'h0, hl;
   logic [15:0] len = 16'h0000;
   logic [1:0] fsel = 2'h0;
   logic sq, ack, wheel, fb, dm, irq, f, w;
   wsf_pkg::wsf_fault_t flt;
   int n_errors = 0, check_count = 0, r, h, n, c;

   initial forever #5 clk_i = ~clk_i;

   wsf_top #(.DIAG_CYC(DC)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
      .dat_i(wd), .dat_o(rd), .ack_o(ack), .peak_level_i(peak),
      .sq_i(sq), .fault_i(flt), .wheel_o(wheel), .hyst_fb_o(fb),
      .hyst_level_o(hl), .diag_mode_o(dm), .irq_o(irq));
   wsf_sensor_model i_sens (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
      .len_i(len), .fsel_i(fsel), .sq_o(sq), .fault_o(flt));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         n_errors++;
         $display("[ERR] %s exp %0h got %0h", nm, e, s);
      end
   endtask
   task stop_test;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= wr; adr <= a; wd <= d;
      for (k = 0; k < 20; k++) begin
         @(posedge clk_i);
         if (ack === 1'b1) break;
      end
      q = rd;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      if (k == 20) begin
         chk("ack", 0, 1);
         stop_test;
      end
   endtask
   task kick(input int l);
      @(posedge clk_i);
      go <= 1'b1; len <= l[15:0];
      @(posedge clk_i);
      go <= 1'b0;
   endtask
   // Rise delay, high width and feedback seen for one sensor pulse
   task pulse(input int l);
      kick(l);
      f = fb;
      for (r = 1; r < 3000 && wheel !== 1'b1; r++) begin
         @(posedge clk_i);
         f = f | fb;
      end
      for (h = 0; h < 3000 && wheel === 1'b1; h++) @(posedge clk_i);
      repeat (1500) @(posedge clk_i);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task t_reset;
      wb(0, wsf_pkg::ADDR_STAT, 0);
      chk("tfilt_rst", q[31:8], wsf_pkg::FILT_MIN_CYC);
      wb(0, wsf_pkg::ADDR_MODE, 0);
      chk("mode_rst", q, 0);
      wb(0, 8'hFC, 0);
      chk("unmapped", q, 0);
      $display("test reset done");
   endtask
   task t_filt;
      for (c = 0; c < 4; c++) begin
         wb(1, wsf_pkg::ADDR_MODE, {28'h0, c[1:0], 2'b01});
         pulse(100);
         chk("spike", r, 3000);
         chk("fb_src", f, !c[0]);
         pulse(1000);
         chk("rise_dly", r >= 398 && r <= 408, 1);
         chk("width", c[1] ? (h >= 992 && h <= 1008) :
            (h >= 592 && h <= 608), 1);
      end
      wb(0, wsf_pkg::ADDR_STAT, 0);
      chk("tfilt_lim", q[31:8], wsf_pkg::FILT_MIN_CYC);
      wb(0, wsf_pkg::ADDR_IRQ_ST, 0);
      chk("edge_irq", q[1], 1);
      $display("test filter done");
   endtask
   task t_full;
      wb(1, wsf_pkg::ADDR_MODE, 0);
      wb(1, wsf_pkg::ADDR_MODE, 3);
      wb(0, wsf_pkg::ADDR_STAT, 0);
      chk("tfilt_en", q[31:8], wsf_pkg::FILT_MAX_CYC);
      wb(1, wsf_pkg::ADDR_OVRD, 32'h10);
      wb(0, wsf_pkg::ADDR_STAT, 0);
      chk("tfilt_fix", q[31:8], wsf_pkg::FILT_MIN_CYC);
      wb(1, wsf_pkg::ADDR_OVRD, 0);
      wb(1, wsf_pkg::ADDR_MODE, 0);
      wb(1, wsf_pkg::ADDR_MODE, 3);
      // Second period is short and clamps; third is 16000 cycles
      kick(21000);
      repeat (23998) @(posedge clk_i);
      kick(2000);
      repeat (1000) @(posedge clk_i);
      wb(0, wsf_pkg::ADDR_STAT, 0);
      chk("tfilt_clmp", q[31:8], wsf_pkg::FILT_MIN_CYC);
      repeat (15220) @(posedge clk_i);
      kick(2000);
      repeat (3000) @(posedge clk_i);
      wb(0, wsf_pkg::ADDR_STAT, 0);
      chk("tfilt_adp", q[31:8] >= 495 && q[31:8] <= 505, 1);
      $display("test full done");
   endtask
   task t_hyst;
      wb(1, wsf_pkg::ADDR_MODE, 1);
      peak <= 3'h2;
      wb(1, wsf_pkg::ADDR_HYST, 5);
      repeat (3) @(posedge clk_i);
      chk("hyst_min", hl, 5);
      wb(1, wsf_pkg::ADDR_HYST, 32'h25);
      repeat (3) @(posedge clk_i);
      chk("hyst_frc", hl, wsf_pkg::HYST_LOWEST);
      wb(1, wsf_pkg::ADDR_HYST, 5);
      $display("test hyst done");
   endtask
   task diag_run;
      wb(1, wsf_pkg::ADDR_DIAG, 1);
      for (n = 0; n < 10 && dm !== 1'b1; n++) @(posedge clk_i);
      kick(20);
      w = 1'b0;
      for (n = 2; n < 500 && dm === 1'b1; n++) begin
         @(posedge clk_i);
         w = w | wheel;
      end
      chk("diag_quiet", w, 0);
      chk("diag_len", n >= DC && n <= DC + 4, 1);
      repeat (3) @(posedge clk_i);
      wb(0, wsf_pkg::ADDR_STAT, 0);
   endtask
   task t_diag;
      wb(1, wsf_pkg::ADDR_DIAG, 1);
      wb(0, wsf_pkg::ADDR_DIAG, 0);
      chk("diag_lim", q[0], 0);
      wb(1, wsf_pkg::ADDR_MODE, 3);
      wb(1, wsf_pkg::ADDR_IRQ_EN, 1);
      fsel <= 2'h2;
      diag_run;
      chk("diag_flt", q[1:0], 2'h3);
      chk("irq_on", irq, 1);
      wb(1, wsf_pkg::ADDR_IRQ_EN, 0);
      repeat (2) @(posedge clk_i);
      chk("irq_mask", irq, 0);
      fsel <= 2'h0;
      diag_run;
      chk("diag_ok", q[1:0], 2'h2);
      wb(1, wsf_pkg::ADDR_IRQ_EN, 1);
      wb(1, wsf_pkg::ADDR_IRQ_CLR, 1);
      repeat (2) @(posedge clk_i);
      chk("irq_clr", irq, 0);
      $display("test diag done");
   endtask

   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_filt;
      t_hyst;
      t_diag;
      t_full;
      stop_test;
   end
endmodule
